//--- hdl/level_monitor_device.sv
// Overrange, fast threshold detect, peak monitor and control bit insertion
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
module level_monitor_device import level_monitor_pkg::*; #(
	parameter int LATENCY = UPPER_LATENCY
) (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [DATA_W-1:0] reg_rdata,
	// Converter samples
	input wire logic sample_valid,
	input wire logic [CHANNELS-1:0][SAMPLE_W-1:0] sample_in,
	input wire logic [CHANNELS-1:0] sample_overrange,
	input wire logic [VCONV-1:0] vconv_overrange,
	input wire logic decimated_en,
	// Threshold pins
	output logic threshold_flag_pin_ch0,
	output logic threshold_flag_pin_ch1,
	// Link side
	level_link_if.tx link
);
	localparam int PIPE = LATENCY;

	logic [MAG_W-1:0] upper_threshold, lower_threshold;
	logic [DWELL_W-1:0] dwell_time;
	logic [PERIOD_W-1:0] period;
	logic [DATA_W-1:0] upper_pend, lower_pend, dwell_pend;
	logic [2*DATA_W-1:0] period_pend;
	logic [DATA_W-1:0] monitor_control, link_a, link_b, sel_a, sel_b;
	logic [DATA_W-1:0] or_clear, ctrl_count;
	logic [VCONV-1:0] or_status;
	logic [MAG_W-1:0] peak_hold, peak_store;
	logic [PERIOD_W-1:0] timer;
	logic en_q, new_peak;
	logic [FRAME_BITS-1:0] frame_shift;
	logic [COUNT_W-1:0] bits_left;
	logic [CHANNELS-1:0] fd;
	logic [CHANNELS-1:0][MAG_W-1:0] mag;
	logic [CHANNELS-1:0][SAMPLE_W-1:0] stage_word;
	logic [CHANNELS-1:0] stage_or;
	logic [PIPE-1:0] valid_pipe;

	// Register write decode
	wire wr_upper_low = reg_write && reg_addr == OFF_UPPER_LOW;
	wire wr_upper_high = reg_write && reg_addr == OFF_UPPER_HIGH;
	wire wr_lower_low = reg_write && reg_addr == OFF_LOWER_LOW;
	wire wr_lower_high = reg_write && reg_addr == OFF_LOWER_HIGH;
	wire wr_dwell_low = reg_write && reg_addr == OFF_DWELL_LOW;
	wire wr_dwell_high = reg_write && reg_addr == OFF_DWELL_HIGH;
	wire wr_period_0 = reg_write && reg_addr == OFF_PERIOD_0;
	wire wr_period_1 = reg_write && reg_addr == OFF_PERIOD_1;
	wire wr_period_2 = reg_write && reg_addr == OFF_PERIOD_2;
	wire wr_mon = reg_write && reg_addr == OFF_MON_CONTROL;
	wire wr_link_a = reg_write && reg_addr == OFF_LINK_EN_A;
	wire wr_link_b = reg_write && reg_addr == OFF_LINK_EN_B;
	wire wr_sel_a = reg_write && reg_addr == OFF_SEL_A;
	wire wr_sel_b = reg_write && reg_addr == OFF_SEL_B;
	wire wr_or_clear = reg_write && reg_addr == OFF_OR_CLEAR;
	wire wr_count = reg_write && reg_addr == OFF_CTRL_COUNT;

	// Read selection; unmapped addresses read zero
	wire [DATA_W-1:0] read_mux =
		reg_addr == OFF_UPPER_LOW ? upper_threshold[7:0] :
		reg_addr == OFF_UPPER_HIGH ? {3'h0, upper_threshold[12:8]} :
		reg_addr == OFF_LOWER_LOW ? lower_threshold[7:0] :
		reg_addr == OFF_LOWER_HIGH ? {3'h0, lower_threshold[12:8]} :
		reg_addr == OFF_DWELL_LOW ? dwell_time[7:0] :
		reg_addr == OFF_DWELL_HIGH ? dwell_time[15:8] :
		reg_addr == OFF_MON_CONTROL ? monitor_control :
		reg_addr == OFF_PERIOD_0 ? period[7:0] :
		reg_addr == OFF_PERIOD_1 ? period[15:8] :
		reg_addr == OFF_PERIOD_2 ? period[23:16] :
		reg_addr == OFF_PEAK_LOW ? peak_hold[7:0] :
		reg_addr == OFF_PEAK_HIGH ? {3'h0, peak_hold[12:8]} :
		reg_addr == OFF_LINK_EN_A ? link_a :
		reg_addr == OFF_LINK_EN_B ? link_b :
		reg_addr == OFF_SEL_A ? sel_a :
		reg_addr == OFF_SEL_B ? sel_b :
		reg_addr == OFF_OR_CLEAR ? or_clear :
		reg_addr == OFF_OR_STATUS ? or_status :
		reg_addr == OFF_CTRL_COUNT ? ctrl_count : BYTE_ZERO;

	// Sticky overrange: new events win over the clear mask
	wire [VCONV-1:0] next_or_status =
		(or_status & ~or_clear) | vconv_overrange; // [RULE4] [RULE5]

	// Multi-byte registers commit on the high byte
	always_ff @(posedge clock) begin
		if (srst) begin
			upper_pend <= BYTE_ZERO;
			lower_pend <= BYTE_ZERO;
			dwell_pend <= BYTE_ZERO;
			period_pend <= '0;
			upper_threshold <= UPPER_RESET;
			lower_threshold <= LOWER_RESET;
			dwell_time <= DWELL_RESET;
			period <= PERIOD_RESET;
		end else begin
			if (wr_upper_low) upper_pend <= reg_wdata;
			if (wr_lower_low) lower_pend <= reg_wdata;
			if (wr_dwell_low) dwell_pend <= reg_wdata;
			if (wr_period_0) period_pend[7:0] <= reg_wdata;
			if (wr_period_1) period_pend[15:8] <= reg_wdata;
			if (wr_upper_high)
				upper_threshold <= {reg_wdata[4:0], upper_pend}; // [RULE24]
			if (wr_lower_high)
				lower_threshold <= {reg_wdata[4:0], lower_pend}; // [RULE9]
			if (wr_dwell_high)
				dwell_time <= {reg_wdata, dwell_pend}; // [RULE10] [RULE24]
			if (wr_period_2)
				period <= {reg_wdata, period_pend}; // [RULE12] [RULE24]
		end
	end

	// Single byte control registers, status and read data
	always_ff @(posedge clock) begin
		if (srst) begin
			monitor_control <= BYTE_ZERO;
			link_a <= BYTE_ZERO;
			link_b <= BYTE_ZERO;
			sel_a <= BYTE_ZERO;
			sel_b <= BYTE_ZERO;
			or_clear <= BYTE_ZERO;
			ctrl_count <= BYTE_ZERO;
			or_status <= '0;
			reg_rdata <= BYTE_ZERO;
		end else begin
			if (wr_mon) monitor_control <= reg_wdata;
			if (wr_link_a) link_a <= reg_wdata;
			if (wr_link_b) link_b <= reg_wdata;
			if (wr_sel_a) sel_a <= reg_wdata;
			if (wr_sel_b) sel_b <= reg_wdata;
			if (wr_or_clear) or_clear <= reg_wdata;
			if (wr_count) ctrl_count <= reg_wdata;
			or_status <= next_or_status;
			reg_rdata <= reg_read ? read_mux : BYTE_ZERO;
		end
	end

	// Valid marker travels with the samples
	always_ff @(posedge clock) begin
		if (srst) valid_pipe <= '0;
		else valid_pipe <= {valid_pipe[PIPE-2:0], sample_valid};
	end

	// Per channel magnitude, compare pipeline and hysteresis
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
		logic [SAMPLE_W-1:0] absval;
		logic [PIPE-1:0] above_pipe, below_pipe, or_pipe;
		logic [SAMPLE_W-1:0] data_pipe [PIPE];
		logic [DWELL_W-1:0] below_count;
		logic hold_flag;
		assign absval = sample_in[ch][SAMPLE_W-1] ?
			(~sample_in[ch] + SAMPLE_ONE) : sample_in[ch];
		assign mag[ch] = absval[SAMPLE_W-1] ? MAG_MAX : absval[MAG_W-1:0];
		assign stage_word[ch] = data_pipe[PIPE-1];
		assign stage_or[ch] = or_pipe[PIPE-1];
		assign fd[ch] = hold_flag;

		// Delay line sets the 28-cycle sample to indicator latency
		always_ff @(posedge clock) begin
			if (srst) begin
				above_pipe <= '0;
				below_pipe <= '0;
				or_pipe <= '0;
			end else begin
				above_pipe <= {above_pipe[PIPE-2:0],
					mag[ch] > upper_threshold}; // [RULE6] [RULE8]
				below_pipe <= {below_pipe[PIPE-2:0],
					mag[ch] < lower_threshold}; // [RULE9]
				or_pipe <= {or_pipe[PIPE-2:0], sample_overrange[ch]}; // [RULE2]
			end
		end

		// Sample words share the same delay as the indicators
		always_ff @(posedge clock) begin
			data_pipe[0] <= sample_in[ch];
			for (int i = 1; i < PIPE; i++) data_pipe[i] <= data_pipe[i-1];
		end

		// Set at once; clear after staying below longer than dwell
		always_ff @(posedge clock) begin
			if (srst) begin
				hold_flag <= 1'b0;
				below_count <= '0;
			end else if (above_pipe[PIPE-1]) begin
				hold_flag <= 1'b1; // [RULE6]
				below_count <= '0;
			end else if (below_pipe[PIPE-1]) begin
				if (below_count >= dwell_time) hold_flag <= 1'b0; // [RULE7]
				else below_count <= below_count + DWELL_ONE; // [RULE10]
			end else begin
				below_count <= '0;
			end
		end
	end

	// Dedicated pins per channel
	assign threshold_flag_pin_ch0 = fd[0]; // [RULE1]
	assign threshold_flag_pin_ch1 = fd[1]; // [RULE1]

	// Peak monitor on the selected channel
	wire mon_en = monitor_control[MON_ENABLE_BIT]; // [RULE14]
	wire mon_start = mon_en && !en_q;
	wire [MAG_W-1:0] mon_mag = mag[monitor_control[MON_CHSEL_BIT]];

	// Countdown at the decimated rate, store keeps the maximum
	always_ff @(posedge clock) begin
		if (srst) begin
			en_q <= 1'b0;
			timer <= '0;
			peak_store <= '0;
			peak_hold <= '0;
			new_peak <= 1'b0;
		end else begin
			en_q <= mon_en;
			new_peak <= 1'b0;
			if (!mon_en) begin
				timer <= '0;
			end else if (mon_start) begin
				timer <= period; // [RULE15]
				peak_store <= mon_mag; // [RULE16]
			end else if (decimated_en) begin
				if (timer == PERIOD_ONE) begin
					peak_hold <= peak_store; // [RULE17] [RULE12]
					timer <= period; // [RULE17] [RULE13]
					peak_store <= mon_mag; // [RULE17]
					new_peak <= 1'b1;
				end else begin
					timer <= timer - PERIOD_ONE; // [RULE15]
					if (mon_mag > peak_store) peak_store <= mon_mag; // [RULE16]
				end
			end
		end
	end

	// Frame serializer, one bit per output sample, zero when idle
	wire stream_en = link_a[1:0] == LINK_A_EN && link_b[LINK_B_EN_BIT];
	wire stream_bit = bits_left != '0 && frame_shift[FRAME_BITS-1];
	always_ff @(posedge clock) begin
		if (srst) begin
			frame_shift <= '0;
			bits_left <= '0;
		end else if (new_peak && stream_en) begin
			frame_shift <= frame_build(peak_hold); // [RULE21] [RULE23]
			bits_left <= FRAME_LEN;
		end else if (bits_left != '0 && valid_pipe[PIPE-1]) begin
			frame_shift <= {frame_shift[FRAME_BITS-2:0], 1'b0}; // [RULE21]
			bits_left <= bits_left - COUNT_ONE;
		end
	end

	// Picks the source for one control bit slot
	function automatic logic pick(input logic [1:0] code,
		input logic orr, input logic flag, input logic strm);
		case (ctrl_source_t'(code))
			SRC_OVERRANGE: pick = orr; // [RULE3]
			SRC_FLAG: pick = flag; // [RULE11]
			SRC_STREAM: pick = strm; // [RULE23]
			default: pick = 1'b0;
		endcase
	endfunction

	// Link output stage: 14-bit word, two zero tail bits, control bits
	always_ff @(posedge clock) begin
		if (srst) begin
			link.valid <= 1'b0;
			link.word <= '0;
			link.ctrl <= '0;
		end else begin
			link.valid <= valid_pipe[PIPE-1];
			for (int c = 0; c < CHANNELS; c++) begin
				link.word[c] <= {stage_word[c], 2'h0}; // [RULE22]
				link.ctrl[c][2] <= ctrl_count[1:0] > 2'h0 &&
					pick(sel_a[1:0], stage_or[c], fd[c], stream_bit); // [RULE19]
				link.ctrl[c][1] <= ctrl_count[1:0] > 2'h1 &&
					pick(sel_a[3:2], stage_or[c], fd[c], stream_bit); // [RULE19]
				link.ctrl[c][0] <= ctrl_count[1:0] > 2'h2 &&
					pick(sel_b[1:0], stage_or[c], fd[c], stream_bit); // [RULE20]
			end
		end
	end
endmodule

//--- hdl/level_monitor_pkg.sv
// Constants, types and frame helpers shared by the level monitor ends
// Operation
// RULE1 - Each channel drives its own threshold pin
// RULE2 - Overrange indicator follows its sample latency
// RULE3 - Overrange may ride in control bits
// RULE4 - Eight sticky overrange bits until software clears
// RULE5 - Clear register clears only selected sticky bits
// RULE6 - Flag sets at once above upper threshold
// RULE7 - Flag clears after below-lower longer than dwell
// RULE8 - Upper compare path latency is 28 cycles
// RULE9 - Lower threshold 13 bits, full resolution compare
// RULE10 - Dwell 1 to 65535 cycles, two bytes
// RULE11 - Software enables flag in control selections
// RULE12 - Peak over 24-bit period, 13-bit result
// RULE13 - Software programs only even period values
// RULE14 - Monitor control bit 1 enables peak detector
// RULE15 - Enable loads period into decimated countdown
// RULE16 - Store starts with magnitude, keeps maximum
// RULE17 - At count one copy peak, reload, restart
// RULE18 - Software sets link enable bits for stream
// RULE19 - Up to three control bits, MSB first
// RULE20 - Software programs selections and bit count
// RULE21 - Peak frame 25 bits as five subframes
// RULE22 - Output word 16 bits, 14 plus zeros
// RULE23 - Subframe starts with one; idle slots zero
// RULE24 - Byte pairs take effect after high byte
package level_monitor_pkg;
	// Widths and counts
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int SAMPLE_W = 14;
	localparam int MAG_W = 13;
	localparam int CHANNELS = 2;
	localparam int VCONV = 8;
	localparam int CTRL_SLOTS = 3;
	localparam int WORD_W = 16;
	localparam int UPPER_LATENCY = 28;
	localparam int PERIOD_W = 24;
	localparam int DWELL_W = 16;
	localparam int FRAME_BITS = 25;
	localparam int SUBFRAME_BITS = 5;
	localparam int SUBFRAMES = 5;
	localparam int NIBBLE = 4;
	localparam int PAYLOAD_BITS = 20;
	localparam int PEAK_PAD = 7;
	localparam int COUNT_W = 5;
	// Register offsets
	localparam logic [ADDR_W-1:0] OFF_UPPER_LOW = 12'h247;
	localparam logic [ADDR_W-1:0] OFF_UPPER_HIGH = 12'h248;
	localparam logic [ADDR_W-1:0] OFF_LOWER_LOW = 12'h249;
	localparam logic [ADDR_W-1:0] OFF_LOWER_HIGH = 12'h24A;
	localparam logic [ADDR_W-1:0] OFF_DWELL_LOW = 12'h24B;
	localparam logic [ADDR_W-1:0] OFF_DWELL_HIGH = 12'h24C;
	localparam logic [ADDR_W-1:0] OFF_MON_CONTROL = 12'h270;
	localparam logic [ADDR_W-1:0] OFF_PERIOD_0 = 12'h271;
	localparam logic [ADDR_W-1:0] OFF_PERIOD_1 = 12'h272;
	localparam logic [ADDR_W-1:0] OFF_PERIOD_2 = 12'h273;
	localparam logic [ADDR_W-1:0] OFF_PEAK_LOW = 12'h274;
	localparam logic [ADDR_W-1:0] OFF_PEAK_HIGH = 12'h275;
	localparam logic [ADDR_W-1:0] OFF_LINK_EN_A = 12'h279;
	localparam logic [ADDR_W-1:0] OFF_LINK_EN_B = 12'h27A;
	localparam logic [ADDR_W-1:0] OFF_SEL_A = 12'h559;
	localparam logic [ADDR_W-1:0] OFF_SEL_B = 12'h55A;
	localparam logic [ADDR_W-1:0] OFF_OR_CLEAR = 12'h562;
	localparam logic [ADDR_W-1:0] OFF_OR_STATUS = 12'h563;
	localparam logic [ADDR_W-1:0] OFF_CTRL_COUNT = 12'h58F;
	// Field positions
	localparam int MON_ENABLE_BIT = 1;
	localparam int MON_CHSEL_BIT = 0;
	localparam int LINK_B_EN_BIT = 1;
	localparam logic [1:0] LINK_A_EN = 2'h3;
	// Reset values
	localparam logic [MAG_W-1:0] UPPER_RESET = 13'h1FFF;
	localparam logic [MAG_W-1:0] LOWER_RESET = 13'h0000;
	localparam logic [DWELL_W-1:0] DWELL_RESET = 16'h0001;
	localparam logic [PERIOD_W-1:0] PERIOD_RESET = 24'h000050;
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	// Arithmetic constants
	localparam logic [SAMPLE_W-1:0] SAMPLE_ONE = 14'h0001;
	localparam logic [MAG_W-1:0] MAG_MAX = 13'h1FFF;
	localparam logic [DWELL_W-1:0] DWELL_ONE = 16'h0001;
	localparam logic [PERIOD_W-1:0] PERIOD_ONE = 24'h000001;
	localparam logic [COUNT_W-1:0] COUNT_ONE = 5'h01;
	localparam logic [COUNT_W-1:0] FRAME_LEN = 5'h19;
	localparam logic START_BIT = 1'b1;
	// Control bit sources
	typedef enum logic [1:0] {SRC_ZERO, SRC_OVERRANGE, SRC_FLAG, SRC_STREAM}
		ctrl_source_t;

	// Builds the framed peak: each subframe is a start bit and a nibble
	function automatic logic [FRAME_BITS-1:0] frame_build(
		input logic [MAG_W-1:0] peak);
		logic [PAYLOAD_BITS-1:0] d;
		logic [FRAME_BITS-1:0] f;
		d = {peak, {PEAK_PAD{1'b0}}};
		f = '0;
		for (int k = 0; k < SUBFRAMES; k++) begin
			f[FRAME_BITS-1-SUBFRAME_BITS*k] = START_BIT;
			f[FRAME_BITS-2-SUBFRAME_BITS*k -: NIBBLE] =
				d[PAYLOAD_BITS-1-NIBBLE*k -: NIBBLE];
		end
		return f;
	endfunction

	// True when every subframe carries its start bit
	function automatic logic frame_ok(input logic [FRAME_BITS-1:0] f);
		logic ok;
		ok = 1'b1;
		for (int k = 0; k < SUBFRAMES; k++) begin
			ok = ok & (f[FRAME_BITS-1-SUBFRAME_BITS*k] == START_BIT);
		end
		return ok;
	endfunction

	// Recovers the 13-bit peak from a frame
	function automatic logic [MAG_W-1:0] frame_peak(
		input logic [FRAME_BITS-1:0] f);
		logic [PAYLOAD_BITS-1:0] d;
		d = '0;
		for (int k = 0; k < SUBFRAMES; k++) begin
			d[PAYLOAD_BITS-1-NIBBLE*k -: NIBBLE] =
				f[FRAME_BITS-2-SUBFRAME_BITS*k -: NIBBLE];
		end
		return d[PAYLOAD_BITS-1 -: MAG_W];
	endfunction
endpackage

//--- hdl/level_link_if.sv
// Sample link between the monitor device and the control bit receiver
`timescale 1ns/100ps
interface level_link_if;
	import level_monitor_pkg::*;
	logic valid;
	logic [CHANNELS-1:0][WORD_W-1:0] word;
	logic [CHANNELS-1:0][CTRL_SLOTS-1:0] ctrl;
	modport tx (output valid, output word, output ctrl);
	modport rx (input valid, input word, input ctrl);
endinterface

//--- hdl/level_monitor_receiver.sv
// Receiver end: recovers samples and the framed peak from control bits
`timescale 1ns/100ps
module level_monitor_receiver import level_monitor_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Link side
	level_link_if.rx link,
	// User configuration
	input wire logic [1:0] stream_slot,
	// User results
	output logic [CHANNELS-1:0][SAMPLE_W-1:0] sample_out,
	output logic sample_out_valid,
	output logic [MAG_W-1:0] peak_value,
	output logic peak_valid,
	output logic frame_error
);
	typedef enum logic {HUNT, COLLECT} rx_state_t;
	rx_state_t state;
	logic [FRAME_BITS-2:0] shreg;
	logic [COUNT_W-1:0] count;

	// Slot 0 is the most significant control bit
	wire [1:0] slot_idx = 2'h2 - stream_slot; // [RULE19]
	wire rx_bit = link.ctrl[0][slot_idx];
	wire [FRAME_BITS-1:0] full_frame = {shreg, rx_bit};
	wire last_bit = count == FRAME_LEN - COUNT_ONE;

	// Sample words without tail bits
	always_ff @(posedge clock) begin
		if (srst) begin
			sample_out <= '0;
			sample_out_valid <= 1'b0;
		end else begin
			sample_out_valid <= link.valid;
			for (int c = 0; c < CHANNELS; c++)
				sample_out[c] <= link.word[c][WORD_W-1 -: SAMPLE_W]; // [RULE22]
		end
	end

	// Frame hunt and collect; any one seen while hunting opens a frame
	always_ff @(posedge clock) begin
		if (srst) begin
			state <= HUNT;
			shreg <= '0;
			count <= '0;
			peak_value <= '0;
			peak_valid <= 1'b0;
			frame_error <= 1'b0;
		end else begin
			peak_valid <= 1'b0;
			frame_error <= 1'b0;
			if (link.valid) begin
				case (state)
					HUNT: begin
						if (rx_bit == START_BIT) begin // [RULE23]
							shreg <= {{(FRAME_BITS-2){1'b0}}, rx_bit};
							count <= COUNT_ONE;
							state <= COLLECT;
						end
					end
					COLLECT: begin
						shreg <= full_frame[FRAME_BITS-2:0];
						count <= count + COUNT_ONE;
						if (last_bit) begin
							state <= HUNT;
							if (frame_ok(full_frame)) begin // [RULE21]
								peak_value <= frame_peak(full_frame);
								peak_valid <= 1'b1;
							end else begin
								frame_error <= 1'b1;
							end
						end
					end
					default: state <= HUNT;
				endcase
			end
		end
	end
endmodule

//--- tb/level_link_chk.sv
// Concurrent checks on the sample link between device and receiver
`timescale 1ns/100ps
module level_link_chk import level_monitor_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Link signals
	input wire logic valid,
	input wire logic [CHANNELS-1:0][WORD_W-1:0] word,
	input wire logic [CHANNELS-1:0][CTRL_SLOTS-1:0] ctrl
);
	logic [4:0] fcnt;
	wire logic top_bit = ctrl[0][CTRL_SLOTS-1];

	// Position inside a stream frame on the top control slot
	always_ff @(posedge clock) begin
		if (srst)
			fcnt <= 5'h00;
		else if (valid && (fcnt != 5'h00 || top_bit))
			fcnt <= (fcnt == 5'h18) ? 5'h00 : fcnt + 5'h01;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	// Frame positions that hold a start bit or padding
	sequence s_start_pos;
		valid && (fcnt inside {5'h05, 5'h0A, 5'h0F, 5'h14});
	endsequence
	sequence s_pad_pos;
		valid && (fcnt inside {5'h11, 5'h12, 5'h13, 5'h15, 5'h16, 5'h17, 5'h18});
	endsequence

	property p_tail_ch0; valid |-> word[0][1:0] == 2'h0; endproperty
	property p_tail_ch1; valid |-> word[1][1:0] == 2'h0; endproperty
	property p_start_bits; s_start_pos |-> top_bit; endproperty
	property p_pad_zero; s_pad_pos |-> !top_bit; endproperty
	property p_reset_quiet; $fell(srst) |-> !valid && word == '0; endproperty
	property p_ctrl_quiet; $fell(srst) |-> (ctrl == '0) [*2]; endproperty
	property p_valid_rise; $fell(srst) |-> ##[1:40] valid; endproperty
	property p_slot2_zero; ctrl[0][0] == 1'b0 && ctrl[1][0] == 1'b0; endproperty

	a_tail_ch0: assert property (p_tail_ch0) else $error("word tail ch0");
	a_tail_ch1: assert property (p_tail_ch1) else $error("word tail ch1");
	a_start_bits: assert property (p_start_bits) else $error("start bit");
	a_pad_zero: assert property (p_pad_zero) else $error("frame padding");
	a_reset_quiet: assert property (p_reset_quiet) else $error("reset word");
	a_ctrl_quiet: assert property (p_ctrl_quiet) else $error("reset ctrl");
	a_valid_rise: assert property (p_valid_rise) else $error("no valid");
	a_slot2_zero: assert property (p_slot2_zero) else $error("slot2 busy");
endmodule

//--- tb/testbench.sv
// Self-checking bench for the level monitor device and receiver pair
`timescale 1ns/100ps
module testbench;
	import level_monitor_pkg::*;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic [CHANNELS-1:0][SAMPLE_W-1:0] sample_in = '0;
	logic [CHANNELS-1:0] sample_overrange = '0;
	logic [VCONV-1:0] vconv_overrange = '0;
	logic decimated_en = 1'b0;
	logic [1:0] pin;
	logic [CHANNELS-1:0][SAMPLE_W-1:0] sample_out;
	logic sample_out_valid;
	logic peak_valid;
	logic frame_error;
	logic [MAG_W-1:0] peak_value;
	logic [31:0] rng = 32'h45DB17F8;
	int span = 0, fail_count = 0, tests_run = 0, cycles = 0;
	int upper = 8191, lower = 0, dwell = 1, n_pk = 0;
	int tmr, store, last_pk, per = 40;
	int fl[2], bc[2], exp_pk[$];
	int hq[2][$];
	int sq[2][$];
	int spans[5] = '{5000, 1500, 3000, 8191, 1000};
	bit dec_run = 0, mon_on = 0, chk_flag = 0;

	level_link_if level_link_if_inst ();
	level_monitor_device level_monitor_device_inst (.clock(clock),
		.srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.sample_valid(1'b1), .sample_in(sample_in),
		.sample_overrange(sample_overrange),
		.vconv_overrange(vconv_overrange), .decimated_en(decimated_en),
		.threshold_flag_pin_ch0(pin[0]), .threshold_flag_pin_ch1(pin[1]),
		.link(level_link_if_inst));
	level_monitor_receiver level_monitor_receiver_inst (.clock(clock),
		.srst(srst), .link(level_link_if_inst), .stream_slot(2'h0),
		.sample_out(sample_out), .sample_out_valid(sample_out_valid),
		.peak_value(peak_value), .peak_valid(peak_valid),
		.frame_error(frame_error));
	level_link_chk level_link_chk_inst (.clock(clock), .srst(srst),
		.valid(level_link_if_inst.valid), .word(level_link_if_inst.word),
		.ctrl(level_link_if_inst.ctrl));

	always #25 clock = ~clock;

	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction

	// Magnitude of a signed sample, saturated to the 13-bit range
	function automatic int mag(input logic [SAMPLE_W-1:0] x);
		int v;
		v = $signed(x);
		v = (v < 0) ? -v : v;
		return (v > 8191) ? 8191 : v;
	endfunction

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("Checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		@(posedge clock);
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		check("reg_rdata", reg_rdata, e);
		@(posedge clock);
	endtask

	// Random samples within the current span; slow enable every other cycle
	always @(posedge clock) begin
		for (int c = 0; c < CHANNELS; c++) begin
			rng = xs(rng);
			sample_in[c] <= (span == 0) ? '0 :
				SAMPLE_W'(int'(rng % (2 * span + 1)) - span);
		end
		decimated_en <= dec_run & ~decimated_en;
	end

	// Reference model of flags and peak, compared once outputs settle
	always @(posedge clock) begin
		int m;
		for (int c = 0; c < CHANNELS; c++) begin
			hq[c].push_back(mag(sample_in[c]));
			if (hq[c].size() > UPPER_LATENCY + 1)
				void'(hq[c].pop_front());
			m = hq[c][0];
			if (hq[c].size() == UPPER_LATENCY + 1) begin
				if (m > upper) begin
					fl[c] = 1;
					bc[c] = 0;
				end else if (m < lower) begin
					bc[c]++;
					if (bc[c] > dwell)
						fl[c] = 0;
				end else
					bc[c] = 0;
			end
			sq[c].push_back(sample_in[c]);
			if (sq[c].size() > UPPER_LATENCY + 2)
				void'(sq[c].pop_front());
		end
		if (mon_on && decimated_en) begin
			m = mag(sample_in[0]);
			if (tmr == 1) begin
				exp_pk.push_back(store);
				last_pk = store;
				tmr = per;
				store = m;
			end else begin
				tmr--;
				store = (m > store) ? m : store;
			end
		end
		#1;
		for (int c = 0; c < CHANNELS; c++)
			if (chk_flag) begin
				check("flag", pin[c], fl[c]);
				check("sample", sample_out[c], sq[c][0]);
			end
		if (chk_flag)
			check("sample_valid", sample_out_valid, 1);
		if (peak_valid === 1'b1) begin
			n_pk++;
			check("peak", peak_value, exp_pk.size() ? exp_pk.pop_front() : -1);
		end
		if (!srst)
			check("frame_error", frame_error, 0);
	end

	// Cuts a hang short
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			summarize();
		end
	end

	initial begin
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		rd(OFF_UPPER_HIGH, 8'h1F);
		rd(OFF_DWELL_LOW, 8'h01);
		rd(12'h100, 8'h00);
		wr(OFF_LOWER_LOW, 8'h1D);
		rd(OFF_LOWER_LOW, 8'h00);
		wr(OFF_LOWER_HIGH, 8'h0A);
		rd(OFF_LOWER_LOW, 8'h1D);
		wr(OFF_UPPER_LOW, 8'hFF);
		wr(OFF_UPPER_HIGH, 8'h0F);
		wr(OFF_DWELL_LOW, 8'h03);
		wr(OFF_DWELL_HIGH, 8'h00);
		upper = 4095;
		lower = 2589;
		dwell = 3;
		$display("Test registers done");
		vconv_overrange <= 8'hA5;
		@(posedge clock);
		vconv_overrange <= 8'h00;
		@(posedge clock);
		rd(OFF_OR_STATUS, 8'hA5);
		wr(OFF_OR_CLEAR, 8'h05);
		wr(OFF_OR_CLEAR, 8'h00);
		wr(OFF_OR_STATUS, 8'h00);
		rd(OFF_OR_STATUS, 8'hA0);
		$display("Test sticky done");
		wr(OFF_LINK_EN_A, 8'h03);
		wr(OFF_LINK_EN_B, 8'h02);
		wr(OFF_CTRL_COUNT, 8'h03);
		wr(OFF_SEL_A, 8'h07);
		wr(OFF_PERIOD_0, 8'h28);
		wr(OFF_PERIOD_1, 8'h00);
		wr(OFF_PERIOD_2, 8'h00);
		sample_overrange <= 2'h1;
		repeat (40) @(posedge clock);
		#1;
		check("slot1", level_link_if_inst.ctrl[0][1], 1);
		wr(OFF_CTRL_COUNT, 8'h01);
		repeat (5) @(posedge clock);
		#1;
		check("slot1", level_link_if_inst.ctrl[0][1], 0);
		sample_overrange <= 2'h0;
		wr(OFF_CTRL_COUNT, 8'h03);
		wr(OFF_SEL_A, 8'h0B);
		$display("Test control slots done");
		repeat (40) @(posedge clock);
		chk_flag = 1;
		foreach (spans[i]) begin
			span = spans[i];
			repeat (80) @(posedge clock);
		end
		#1;
		check("flag slot", level_link_if_inst.ctrl[0][1], fl[0]);
		$display("Test threshold done");
		span = 0;
		repeat (35) @(posedge clock);
		wr(OFF_MON_CONTROL, 8'h02);
		repeat (3) @(posedge clock);
		tmr = per;
		store = 0;
		mon_on = 1;
		dec_run = 1;
		span = 3000;
		repeat (500) @(posedge clock);
		dec_run = 0;
		repeat (40) @(posedge clock);
		rd(OFF_PEAK_LOW, last_pk[7:0]);
		rd(OFF_PEAK_HIGH, {3'h0, last_pk[12:8]});
		check("frames", n_pk > 4, 1);
		check("pending", exp_pk.size(), 0);
		$display("Test monitor done");
		summarize();
	end
endmodule
